// ### logic/uart_dma_pkg.sv
// Package for the serial-port to dual-port RAM transfer controller.
// Assumes an 8-bit processor data bus with 16-bit addresses.
package uart_dma_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] REG_BASE              = 16'h2000;
  localparam logic [15:0] TX_TARGET_ADDR_LOW    = 16'h2000;
  localparam logic [15:0] TX_ADDR_HIGH_ENABLE   = 16'h2001;
  localparam logic [15:0] TX_LENGTH_LOW         = 16'h2003;
  localparam logic [15:0] TX_LENGTH_HIGH        = 16'h2004;
  localparam logic [15:0] TX_COUNT_LOW          = 16'h2005;
  localparam logic [15:0] TX_COUNT_HIGH_STATUS  = 16'h2006;
  localparam logic [15:0] RX_TARGET_ADDR_LOW    = 16'h2007;
  localparam logic [15:0] RX_ADDR_HIGH_ENABLE   = 16'h2008;
  localparam logic [15:0] RX_LENGTH_LOW         = 16'h2009;
  localparam logic [15:0] RX_LENGTH_HIGH        = 16'h200a;
  localparam logic [15:0] RX_COUNT_LOW          = 16'h200b;
  localparam logic [15:0] RX_COUNT_HIGH_STATUS  = 16'h200c;
  localparam logic [15:0] DMA_IRQ_CTRL_STATUS   = 16'h200d;
  localparam logic [7:0]  REG_RESET             = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ENABLE_BIT      = 7;
  localparam int LINE_ERROR_BIT  = 7;
  localparam int DONE_BIT        = 4;
  localparam int ABORTED_BIT     = 3;
  localparam int TX_PENDING_BIT  = 3;
  localparam int RX_PENDING_BIT  = 2;
  localparam int TX_IRQ_EN_BIT   = 1;
  localparam int RX_IRQ_EN_BIT   = 0;
  localparam int ADDR_W          = 12;
  localparam int LEN_W           = 11;

  typedef logic [ADDR_W-1:0] ram_addr_t;
  typedef logic [LEN_W-1:0]  length_t;

  // Processor bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  // Dual-port RAM port request
  typedef struct packed {
    logic      we;
    logic      re;
    ram_addr_t addr;
    logic [7:0] wdata;
  } ram_req_t;

  typedef enum logic [1:0] {TX_IDLE, TX_READ, TX_WAIT, TX_SEND} tx_state_t;

endpackage : uart_dma_pkg

// ### logic/uart_dpram_dma_controller.sv
// Transfer controller moving serial-port bytes to and from dual-port RAM.
// Assumes synchronous RAM with one-cycle read latency and a UART on ref_clk.
//
// Functional notes
// RQ1: Full tx transfer sets done bit, read clears.
// RQ2: Stopped tx transfer sets aborted bit, read clears.
// RQ3: Tx sent count high bits at 0x2006.
// RQ4: Rx target address at 0x2007/0x2008.
// RQ5: Bit 7 of 0x2008 enables receive.
// RQ6: Rx requested length at 0x2009/0x200A.
// RQ7: Rx received count at 0x200B/0x200C.
// RQ8: Line errors set bit 7, cleared on reprogram.
// RQ9: Full rx transfer sets done bit, read clears.
// RQ10: Stopped rx transfer sets aborted bit, read clears.
// RQ11: Tx pending bit 3, cleared reading 0x200C.
// RQ12: Rx pending bit 2, cleared reading 0x200C.
// RQ13: Bit 1 gates transmit interrupts.
// RQ14: Bit 0 gates receive interrupts.
// RQ15: All registers reset to zero.
// RQ16: Register file decoded from base 0x2000.
// RQ17: Tx address high and enable at 0x2001.
// RQ18: Tx requested length at 0x2003/0x2004.
// RQ19: Move bytes sequentially until count equals length.
// RQ20: Completion raises pending, latches count, clears enable.
`timescale 1ns/1ns
`default_nettype none
module uart_dpram_dma_controller
  import uart_dma_pkg::*;
(
  input  wire logic                    ref_clk,     // 100 MHz clock
  input  wire logic                    sys_rst,     // Async reset, active high
  input  wire uart_dma_pkg::cpu_req_t  cpu_req,     // Processor bus request
  output var  logic [7:0]              cpu_rdata,   // Registered read data
  output var  uart_dma_pkg::ram_req_t  ram_req,     // RAM request
  input  wire logic [7:0]              ram_rdata,   // RAM data, one cycle after re
  output var  logic                    tx_valid,    // Byte offered to UART
  output var  logic [7:0]              tx_data,     // Byte to UART
  input  wire logic                    tx_ready,    // UART takes byte
  input  wire logic                    rx_valid,    // Byte from UART, one pulse
  input  wire logic [7:0]              rx_data,     // Received byte
  input  wire logic                    rx_line_err, // Parity, framing or overrun
  output var  logic                    tx_irq,      // Transmit interrupt
  output var  logic                    rx_irq       // Receive interrupt
);
  import uart_dma_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  ram_addr_t  tx_target_address;
  length_t    tx_requested_length;
  length_t    tx_sent_count;
  length_t    tx_count;
  logic       tx_transfer_enable;
  logic       tx_done_flag;
  logic       tx_aborted_flag;
  ram_addr_t  rx_target_address;
  length_t    rx_requested_length;
  length_t    rx_received_count;
  length_t    rx_count;
  logic       rx_transfer_enable;
  logic       rx_done_flag;
  logic       rx_aborted_flag;
  logic       rx_line_error_flag;
  logic       tx_irq_pending;
  logic       rx_irq_pending;
  logic       tx_irq_enable;
  logic       rx_irq_enable;
  tx_state_t  tx_state;

  function automatic logic hit(input cpu_req_t r, input logic [15:0] a);
    hit = (r.addr == a);
  endfunction : hit

  logic wr;
  logic rd;
  logic tx_finish;
  logic tx_stop;
  logic rx_finish;
  logic rx_stop;
  logic rx_take;
  logic rx_stat_read;
  logic tx_accept;
  logic tx_fetch;
  length_t next_tx_count;
  assign wr = cpu_req.wr;
  assign rd = cpu_req.rd;
  assign rx_stat_read = rd && hit(cpu_req, RX_COUNT_HIGH_STATUS);
  // Processor dropping the enable bit mid-transfer is a stop
  assign tx_stop = tx_transfer_enable && wr && hit(cpu_req, TX_ADDR_HIGH_ENABLE)
                   && !cpu_req.wdata[ENABLE_BIT];
  assign rx_stop = rx_transfer_enable && wr && hit(cpu_req, RX_ADDR_HIGH_ENABLE)
                   && !cpu_req.wdata[ENABLE_BIT];
  assign tx_finish = tx_transfer_enable && (tx_count == tx_requested_length)
                     && (tx_state == TX_IDLE); // [RQ19]
  assign rx_finish = rx_transfer_enable && (rx_count == rx_requested_length); // [RQ19]
  assign rx_take = rx_transfer_enable && !rx_finish && rx_valid;
  // A byte taken on the stopping edge has left, so it is counted
  assign tx_accept = tx_valid && tx_ready;
  assign next_tx_count = tx_count + length_t'(tx_accept);
  // Read issued from IDLE so RAM data is settled when WAIT samples it; a receive write defers it
  assign tx_fetch = tx_transfer_enable && (tx_state == TX_IDLE) && !tx_finish && !tx_stop
                    && !(wr && hit(cpu_req, TX_ADDR_HIGH_ENABLE)) && !rx_take;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_target_address   <= '0; // [RQ15]
      tx_requested_length <= '0;
      rx_target_address   <= '0;
      rx_requested_length <= '0;
      tx_irq_enable       <= 1'b0;
      rx_irq_enable       <= 1'b0;
    end
    else if (wr)
    begin
      // Decode relative to the 0x2000 base [RQ16]
      if (hit(cpu_req, TX_TARGET_ADDR_LOW))
        tx_target_address[7:0] <= cpu_req.wdata;
      if (hit(cpu_req, TX_ADDR_HIGH_ENABLE))
        tx_target_address[11:8] <= cpu_req.wdata[3:0]; // [RQ17]
      if (hit(cpu_req, TX_LENGTH_LOW))
        tx_requested_length[7:0] <= cpu_req.wdata; // [RQ18]
      if (hit(cpu_req, TX_LENGTH_HIGH))
        tx_requested_length[10:8] <= cpu_req.wdata[2:0]; // [RQ18]
      if (hit(cpu_req, RX_TARGET_ADDR_LOW))
        rx_target_address[7:0] <= cpu_req.wdata; // [RQ4]
      if (hit(cpu_req, RX_ADDR_HIGH_ENABLE))
        rx_target_address[11:8] <= cpu_req.wdata[3:0]; // [RQ4]
      if (hit(cpu_req, RX_LENGTH_LOW))
        rx_requested_length[7:0] <= cpu_req.wdata; // [RQ6]
      if (hit(cpu_req, RX_LENGTH_HIGH))
        rx_requested_length[10:8] <= cpu_req.wdata[2:0]; // [RQ6]
      if (hit(cpu_req, DMA_IRQ_CTRL_STATUS))
      begin
        tx_irq_enable <= cpu_req.wdata[TX_IRQ_EN_BIT];
        rx_irq_enable <= cpu_req.wdata[RX_IRQ_EN_BIT];
      end
    end
  end

  // ****************************************************************
  // Transmit path: RAM read, then hand byte to UART
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_transfer_enable <= 1'b0;
      tx_count           <= '0;
      tx_sent_count      <= '0;
      tx_state           <= TX_IDLE;
      tx_valid           <= 1'b0;
      tx_data            <= REG_RESET;
    end
    else if (tx_stop || tx_finish)
    begin
      tx_transfer_enable <= 1'b0; // [RQ20]
      tx_sent_count      <= next_tx_count; // [RQ20]
      tx_state           <= TX_IDLE;
      tx_valid           <= 1'b0;
    end
    else if (wr && hit(cpu_req, TX_ADDR_HIGH_ENABLE) && cpu_req.wdata[ENABLE_BIT])
    begin
      tx_transfer_enable <= 1'b1;
      tx_count           <= '0;
    end
    else if (tx_transfer_enable)
    begin
      case (tx_state)
        TX_IDLE:
          if (tx_fetch)
            tx_state <= TX_READ; // [RQ19]
        TX_READ: tx_state <= TX_WAIT;
        TX_WAIT:
        begin
          tx_data  <= ram_rdata;
          tx_valid <= 1'b1;
          tx_state <= TX_SEND;
        end
        TX_SEND:
          if (tx_ready)
          begin
            tx_valid <= 1'b0;
            tx_count <= next_tx_count; // [RQ19]
            tx_state <= TX_IDLE;
          end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Receive path: each UART byte written straight to RAM
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_transfer_enable <= 1'b0;
      rx_count           <= '0;
      rx_received_count  <= '0;
      rx_line_error_flag <= 1'b0;
      ram_req            <= '0;
    end
    else
    begin
      ram_req.we <= 1'b0;
      ram_req.re <= 1'b0;
      if (rx_stop || rx_finish)
      begin
        rx_transfer_enable <= 1'b0; // [RQ20]
        rx_received_count  <= rx_count; // [RQ7] [RQ20]
      end
      else if (wr && hit(cpu_req, RX_ADDR_HIGH_ENABLE) && cpu_req.wdata[ENABLE_BIT])
      begin
        // Software sets address and length first [RQ5]
        rx_transfer_enable <= 1'b1; // [RQ5]
        rx_count           <= '0;
        rx_line_error_flag <= 1'b0; // [RQ8]
      end
      else if (rx_take)
      begin
        ram_req.we    <= 1'b1;
        ram_req.addr  <= rx_target_address + ram_addr_t'(rx_count); // [RQ19]
        ram_req.wdata <= rx_data;
        rx_count      <= rx_count + 11'h001;
        if (rx_line_err)
          rx_line_error_flag <= 1'b1; // [RQ8]
      end
      // Receive writes take priority; transmit read waits for every cycle in which rx_take is set
      if (tx_fetch)
      begin
        ram_req.re   <= 1'b1;
        ram_req.addr <= tx_target_address + ram_addr_t'(tx_count); // [RQ19]
      end
    end
  end

  // ****************************************************************
  // Sticky status flags; a set in the clearing cycle wins
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_done_flag    <= 1'b0;
      tx_aborted_flag <= 1'b0;
      rx_done_flag    <= 1'b0;
      rx_aborted_flag <= 1'b0;
      tx_irq_pending  <= 1'b0;
      rx_irq_pending  <= 1'b0;
    end
    else
    begin
      // A stop landing on the last byte is still a full transfer
      if (tx_finish || (tx_stop && next_tx_count == tx_requested_length))
        tx_done_flag <= 1'b1; // [RQ1]
      else if (rd && hit(cpu_req, TX_COUNT_HIGH_STATUS))
        tx_done_flag <= 1'b0; // [RQ1]
      if (tx_stop && next_tx_count != tx_requested_length)
        tx_aborted_flag <= 1'b1; // [RQ2]
      else if (rd && hit(cpu_req, TX_COUNT_HIGH_STATUS))
        tx_aborted_flag <= 1'b0; // [RQ2]
      if (rx_finish)
        rx_done_flag <= 1'b1; // [RQ9]
      else if (rx_stat_read)
        rx_done_flag <= 1'b0; // [RQ9]
      if (rx_stop && rx_count != rx_requested_length)
        rx_aborted_flag <= 1'b1; // [RQ10]
      else if (rx_stat_read)
        rx_aborted_flag <= 1'b0; // [RQ10]
      // Both pending bits are acknowledged by the receive status read
      if (tx_stop || tx_finish)
        tx_irq_pending <= 1'b1; // [RQ20]
      else if (rx_stat_read)
        tx_irq_pending <= 1'b0; // [RQ11]
      if (rx_stop || rx_finish)
        rx_irq_pending <= 1'b1; // [RQ20]
      else if (rx_stat_read)
        rx_irq_pending <= 1'b0; // [RQ12]
    end
  end

  // ****************************************************************
  // Interrupt outputs and read data
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= tx_irq_pending && tx_irq_enable; // [RQ13]
      rx_irq <= rx_irq_pending && rx_irq_enable; // [RQ14]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cpu_rdata <= REG_RESET;
    else if (rd)
    begin
      case (cpu_req.addr)
        TX_TARGET_ADDR_LOW:   cpu_rdata <= tx_target_address[7:0];
        TX_ADDR_HIGH_ENABLE:  cpu_rdata <= {tx_transfer_enable, 3'h0, tx_target_address[11:8]};
        TX_LENGTH_LOW:        cpu_rdata <= tx_requested_length[7:0];
        TX_LENGTH_HIGH:       cpu_rdata <= {5'h00, tx_requested_length[10:8]};
        TX_COUNT_LOW:         cpu_rdata <= tx_sent_count[7:0];
        TX_COUNT_HIGH_STATUS: cpu_rdata <= {3'h0, tx_done_flag, tx_aborted_flag,
                                            tx_sent_count[10:8]}; // [RQ3]
        RX_TARGET_ADDR_LOW:   cpu_rdata <= rx_target_address[7:0];
        RX_ADDR_HIGH_ENABLE:  cpu_rdata <= {rx_transfer_enable, 3'h0, rx_target_address[11:8]};
        RX_LENGTH_LOW:        cpu_rdata <= rx_requested_length[7:0];
        RX_LENGTH_HIGH:       cpu_rdata <= {5'h00, rx_requested_length[10:8]};
        RX_COUNT_LOW:         cpu_rdata <= rx_received_count[7:0]; // [RQ7]
        RX_COUNT_HIGH_STATUS: cpu_rdata <= {rx_line_error_flag, 2'h0, rx_done_flag,
                                            rx_aborted_flag, rx_received_count[10:8]};
        DMA_IRQ_CTRL_STATUS:  cpu_rdata <= {4'h0, tx_irq_pending, rx_irq_pending,
                                            tx_irq_enable, rx_irq_enable};
        default:              cpu_rdata <= REG_RESET;
      endcase
    end
  end

endmodule : uart_dpram_dma_controller
`default_nettype wire

// ### sim/uart_dma_assertions.sv
// Port checker for the serial-port to RAM transfer controller.
// Assumes it is bound onto the controller top module.
`timescale 1ns/1ns
`default_nettype none
module uart_dma_assertions
  import uart_dma_pkg::*;
(
  input wire logic                   ref_clk,     // Clock
  input wire logic                   sys_rst,     // Reset
  input wire uart_dma_pkg::cpu_req_t cpu_req,     // Bus request
  input wire logic [7:0]             cpu_rdata,   // Read data
  input wire uart_dma_pkg::ram_req_t ram_req,     // RAM request
  input wire logic [7:0]             ram_rdata,   // RAM data
  input wire logic                   tx_valid,    // Byte offered
  input wire logic [7:0]             tx_data,     // Byte out
  input wire logic                   tx_ready,    // Byte taken
  input wire logic                   rx_valid,    // Byte in
  input wire logic [7:0]             rx_data,     // Received byte
  input wire logic                   rx_line_err, // Line error
  input wire logic                   tx_irq,      // Tx interrupt
  input wire logic                   rx_irq       // Rx interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic rd_irq = cpu_req.rd && cpu_req.addr == DMA_IRQ_CTRL_STATUS;
  wire logic rd_bad = cpu_req.rd && (cpu_req.addr < REG_BASE || cpu_req.addr > DMA_IRQ_CTRL_STATUS
                      || cpu_req.addr == 16'h2002);
  reset_zero_a: assert property ($fell(sys_rst) |-> !tx_valid && !tx_irq && !rx_irq
    && ram_req == '0 && cpu_rdata == 8'h00) else $error("outputs not clear after reset");
  rdata_hold_a: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_bad |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered byte dropped or changed");
  tx_fetch_a: assert property ($rose(tx_valid) |-> $past(ram_req.re, 2) && tx_data == $past(ram_rdata))
    else $error("offered byte not from RAM");
  rx_store_a: assert property (ram_req.we |-> $past(rx_valid) && ram_req.wdata == $past(rx_data))
    else $error("RAM write without received byte");
  tx_gate_a: assert property (rd_irq ##1 !cpu_rdata[TX_IRQ_EN_BIT] |-> !tx_irq)
    else $error("tx interrupt while disabled");
  rx_gate_a: assert property (rd_irq ##1 !cpu_rdata[RX_IRQ_EN_BIT] |-> !rx_irq)
    else $error("rx interrupt while disabled");
  irq_ack_a: assert property (cpu_req.rd && cpu_req.addr == RX_COUNT_HIGH_STATUS |-> ##2 !tx_irq && !rx_irq)
    else $error("interrupt not acknowledged");
  cover property (tx_valid && tx_ready);
  cover property (ram_req.we && $past(rx_line_err));
  cover property ($rose(tx_irq));
  cover property ($rose(rx_irq));
endmodule : uart_dma_assertions
bind uart_dpram_dma_controller uart_dma_assertions uart_dma_assertions_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .ram_req(ram_req), .ram_rdata(ram_rdata), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_line_err(rx_line_err),
  .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// ### sim/uart_ram_model.sv
// Far side model: shared RAM and the UART transmit sink.
// Assumes one-cycle RAM read latency; receive bytes come from the bench.
`timescale 1ns/1ns
`default_nettype none
module uart_ram_model
  import uart_dma_pkg::*;
(
  input  wire logic                   ref_clk,   // Clock
  input  wire uart_dma_pkg::ram_req_t ram_req,   // RAM request
  output var  logic [7:0]             ram_rdata, // RAM data
  input  wire logic                   tx_valid,  // Byte offered
  input  wire logic [7:0]             tx_data,   // Byte out
  output var  logic                   tx_ready,  // Byte taken
  input  wire logic                   slow       // Stall often
);
  logic [7:0] mem [4096];
  logic [7:0] got [$];
  initial
  begin
    ram_rdata = 8'h00;
    tx_ready  = 1'b0;
  end
  // Idle read data toggles so a late sample never passes for valid
  always @(posedge ref_clk)
  begin
    ram_rdata <= ram_req.re ? mem[ram_req.addr] : ~ram_rdata;
    if (ram_req.we)
      mem[ram_req.addr] <= ram_req.wdata;
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= #1 ($urandom % (slow ? 6 : 1)) == 0;
  end
endmodule : uart_ram_model
`default_nettype wire

// ### sim/tb_uart_dpram_dma_controller.sv
// Self-checking bench for the serial-port to RAM transfer controller.
// Assumes the RAM/UART model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module tb_uart_dpram_dma_controller;
  import uart_dma_pkg::*;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  cpu_req_t   cpu_req = '0;
  logic [7:0] cpu_rdata, ram_rdata, tx_data, rd;
  ram_req_t   ram_req;
  logic       tx_valid, tx_ready, tx_irq, rx_irq;
  logic       rx_valid = 1'b0, rx_line_err = 1'b0, slow = 1'b0;
  logic [7:0] rx_data = 8'h00;
  int         err_total = 0, checked = 0;
  logic [7:0] wv, last = 8'h00;
  logic [15:0] ra [5] = '{RX_TARGET_ADDR_LOW, RX_ADDR_HIGH_ENABLE, RX_LENGTH_LOW, RX_LENGTH_HIGH, DMA_IRQ_CTRL_STATUS};
  logic [7:0]  rm [5] = '{8'hff, 8'h0f, 8'hff, 8'h07, 8'h03};
  always #5 ref_clk = ~ref_clk;
  uart_dpram_dma_controller uart_dpram_dma_controller_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .ram_req(ram_req), .ram_rdata(ram_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_line_err(rx_line_err),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  uart_ram_model ram_model (.ref_clk(ref_clk), .ram_req(ram_req), .ram_rdata(ram_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] seen);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One strobe cycle then one idle cycle, so no strobe is set twice in a time step
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    cpu_req = {w, !w, a, d};
    tick();
    cpu_req = '0;
    rd = cpu_rdata;
    tick();
  endtask : bus
  function automatic logic [7:0] status(input logic e, input logic d, input logic s, input logic [10:0] n);
    return {e, 2'b00, d, s, n[10:8]};
  endfunction : status
  task automatic tx_run(input logic [10:0] len, input logic stop);
    logic [11:0] base;
    int          n;
    base = 12'($urandom);
    ram_model.got.delete();
    for (int i = 0; i < len; i++)
      ram_model.mem[12'(base + i)] = 8'($urandom);
    bus(1, DMA_IRQ_CTRL_STATUS, stop ? 8'h01 : 8'h02);
    bus(1, TX_TARGET_ADDR_LOW, base[7:0]);
    bus(1, TX_LENGTH_LOW, len[7:0]);
    bus(1, TX_LENGTH_HIGH, {5'h00, len[10:8]});
    bus(1, TX_ADDR_HIGH_ENABLE, {4'h8, base[11:8]});
    if (stop)
    begin
      repeat (30) tick();
      bus(1, TX_ADDR_HIGH_ENABLE, {4'h0, base[11:8]});
    end
    for (int i = 0; i < (stop ? 10 : 3000) && ram_model.got.size() < len; i++)
      tick();
    repeat (6) tick();
    n = ram_model.got.size();
    for (int i = 0; i < n; i++)
      chk("tx byte", ram_model.mem[12'(base + i)], ram_model.got[i]);
    if (!stop)
      chk("tx bytes", len, 11'(n));
    chk("tx irq", !stop, tx_irq);
    bus(0, DMA_IRQ_CTRL_STATUS, 8'h00);
    chk("tx pending", 8'h08, rd & 8'h08);
    bus(0, TX_COUNT_LOW, 8'h00);
    chk("tx count low", n[7:0], rd);
    bus(0, TX_COUNT_HIGH_STATUS, 8'h00);
    chk("tx status", status(0, !stop, stop, 11'(n)), rd);
    bus(0, TX_COUNT_HIGH_STATUS, 8'h00);
    chk("tx status again", status(0, 0, 0, 11'(n)), rd);
    bus(0, TX_ADDR_HIGH_ENABLE, 8'h00);
    chk("tx enable", base[11:8], rd & 8'h8f);
    bus(0, RX_COUNT_HIGH_STATUS, 8'h00);
    bus(0, DMA_IRQ_CTRL_STATUS, 8'h00);
    chk("tx pending ack", 8'h00, rd & 8'h08);
  endtask : tx_run
  task automatic rx_run(input logic [10:0] len, input logic stop);
    logic [11:0] base;
    logic [7:0]  sent [$];
    int          n, bad;
    base = 12'($urandom);
    n    = stop ? 2 : len;
    bad  = stop ? -1 : $urandom % n;
    bus(1, DMA_IRQ_CTRL_STATUS, stop ? 8'h02 : 8'h01);
    bus(1, RX_TARGET_ADDR_LOW, base[7:0]);
    bus(1, RX_LENGTH_LOW, len[7:0]);
    bus(1, RX_LENGTH_HIGH, {5'h00, len[10:8]});
    bus(1, RX_ADDR_HIGH_ENABLE, {4'h8, base[11:8]});
    // Back-to-back bytes; a full transfer gets one extra that must be dropped
    for (int i = 0; i <= n - stop; i++)
    begin
      sent.push_back(8'($urandom));
      rx_valid    = 1'b1;
      rx_data     = sent[i];
      rx_line_err = i == bad;
      tick();
    end
    rx_valid    = 1'b0;
    rx_line_err = 1'b0;
    if (stop)
      bus(1, RX_ADDR_HIGH_ENABLE, {4'h0, base[11:8]});
    repeat (4) tick();
    for (int i = 0; i < n; i++)
      chk("rx byte", sent[i], ram_model.mem[12'(base + i)]);
    chk("rx irq", !stop, rx_irq);
    bus(0, DMA_IRQ_CTRL_STATUS, 8'h00);
    chk("rx pending", 8'h04, rd & 8'h04);
    bus(0, RX_COUNT_LOW, 8'h00);
    chk("rx count low", n[7:0], rd);
    bus(0, RX_COUNT_HIGH_STATUS, 8'h00);
    chk("rx status", status(!stop, !stop, stop, 11'(n)), rd);
    chk("rx irq ack", 1'b0, rx_irq);
    bus(0, RX_COUNT_HIGH_STATUS, 8'h00);
    chk("rx status again", status(!stop, 0, 0, 11'(n)), rd);
    bus(0, RX_ADDR_HIGH_ENABLE, 8'h00);
    chk("rx enable", base[11:8], rd & 8'h8f);
  endtask : rx_run
  initial
  begin
    #500000;
    err_total++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'hb9d3));
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    for (int a = 16'h2000; a <= 16'h200e; a++)
    begin
      bus(0, 16'(a), 8'h00);
      chk("reset value", 8'h00, rd);
    end
    for (int i = 0; i < 5; i++)
    begin
      // Bit 7 kept clear so no transfer starts here
      wv = 8'($urandom) & 8'h7f;
      bus(1, ra[i], wv);
      chk("register", last, rd);
      bus(0, ra[i], 8'h00);
      last = wv & rm[i];
      chk("readback", last, rd);
    end
    bus(1, 16'h2002, 8'hff);
    bus(0, 16'h2002, 8'h00);
    chk("unmapped", 8'h00, rd);
    $display("test registers done");
    tx_run(11'h000, 0);
    tx_run(11'h103, 0);
    slow = 1'b1;
    tx_run(11'(5 + $urandom % 20), 0);
    tx_run(11'h028, 1);
    $display("test transmit done");
    rx_run(11'h101, 0);
    rx_run(11'h020, 1);
    rx_run(11'(3 + $urandom % 8), 0);
    $display("test receive done");
    complete_run();
  end
endmodule : tb_uart_dpram_dma_controller
`default_nettype wire
